// ==== logic/buck_ctrl_pkg.sv ====
//----------------------------------------------------------------------
// What this block does
//----------------------------------------------------------------------
package buck_ctrl_pkg;

  //--------------------------------------------------------------------
  // Register map
  //--------------------------------------------------------------------
  localparam logic [7:0] ADDR_LOOP_REF = 8'h00;
  localparam logic [7:0] ADDR_SCALE_CTRL = 8'h01;
  localparam logic [7:0] ADDR_CHIP_ID = 8'h05;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h06;

  //--------------------------------------------------------------------
  // Field positions
  //--------------------------------------------------------------------
  localparam int LOOP_SEL_BIT = 7;
  localparam int ARM_BIT = 6;
  localparam int OC_BIT = 3;
  localparam int TEW_BIT = 2;
  localparam int TSD_BIT = 1;
  localparam int PG_BIT = 0;

  //--------------------------------------------------------------------
  // Reset values
  //--------------------------------------------------------------------
  // Loop select set = divider loop; code of the fixed 0.6 V reference
  localparam logic [6:0] REF_CODE_FIXED = 7'h0a;
  localparam logic [7:0] LOOP_REF_RESET = 8'h8a;
  localparam logic [7:0] SCALE_CTRL_RESET = 8'h00;
  // Vendor code: arbitrary neutral value
  localparam logic [3:0] VENDOR_CODE_DEF = 4'h5;
  localparam logic [3:0] REVISION_DEF = 4'h1;

  //--------------------------------------------------------------------
  // Carriers
  //--------------------------------------------------------------------
  // Analog monitor results, already sampled to the clock
  typedef struct packed {
    logic overcurrent_flag;
    logic thermal_early_warning_flag;
    logic thermal_shutdown_flag;
    logic fb_in_window;   // Feedback pin inside window
    logic vout_in_window; // Sensed output inside window
  } monitor_s;

  // Register write strobe with address and data
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

endpackage

// ==== logic/buck_status_gen.sv ====
`timescale 1ns/100ps
// Builds the fault status byte from the monitor levels
module buck_status_gen
  import buck_ctrl_pkg::*;
(
  // Monitor levels
  input wire monitor_s i_mon,
  input wire logic i_direct_loop,
  // Status byte
  output logic [7:0] o_status
);

  //--------------------------------------------------------------------
  // Status assembly
  //--------------------------------------------------------------------
  // Window comparison follows whichever loop is active
  always_comb begin
    o_status = 8'h00;
    o_status[OC_BIT] = i_mon.overcurrent_flag;
    o_status[TEW_BIT] = i_mon.thermal_early_warning_flag;
    o_status[TSD_BIT] = i_mon.thermal_shutdown_flag;
    o_status[PG_BIT] = i_direct_loop ? i_mon.vout_in_window
                                     : i_mon.fb_in_window;
  end

endmodule

// ==== logic/buck_loop_select_status_regs.sv ====
`timescale 1ns/100ps
module buck_loop_select_status_regs
  import buck_ctrl_pkg::*;
#(
  parameter logic [3:0] VENDOR_CODE = VENDOR_CODE_DEF, // Arbitrary value
  parameter logic [3:0] REVISION = REVISION_DEF
)(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Converter enable level
  input wire logic i_enable,
  // Register access from the serial interface
  input wire reg_wr_s i_wr,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // Analog monitors
  input wire monitor_s i_mon,
  // Loop control to the analog core
  output logic o_direct_loop,
  output logic [6:0] o_ref_code,
  output logic o_power_good
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  logic [7:0] loop_ref_r, loop_ref_nxt;   // Select and code
  logic arm_r, arm_nxt;                   // Scaling armed
  logic [5:0] scale_misc_r, scale_misc_nxt; // Other writable bits
  logic scale_b7_r, scale_b7_nxt;
  logic en_d_r;                           // Enable, last cycle
  logic [7:0] rd_r, rd_nxt;
  logic pg_r;
  logic [7:0] status;
  logic en_rise;
  logic direct_r;       // Register loop active, registered for the pin
  logic [6:0] ref_code_r; // Active reference code, registered

  //--------------------------------------------------------------------
  // Status builder
  //--------------------------------------------------------------------
  buck_status_gen u_status (
    .i_mon(i_mon),
    .i_direct_loop(!loop_ref_r[LOOP_SEL_BIT]),
    .o_status(status)
  );

  assign en_rise = i_enable && !en_d_r;

  //--------------------------------------------------------------------
  // Control registers next state
  //--------------------------------------------------------------------
  // A loop write lands only when armed, so a stray write is harmless
  always_comb begin
    loop_ref_nxt = loop_ref_r;
    arm_nxt = arm_r;
    scale_misc_nxt = scale_misc_r;
    scale_b7_nxt = scale_b7_r;
    if (en_rise || !i_enable) begin
      // Back to the divider loop on each enable assertion
      loop_ref_nxt = LOOP_REF_RESET;
      arm_nxt = 1'b0;
    end else if (i_wr.wr) begin
      case (i_wr.addr)
        ADDR_LOOP_REF: begin
          if (arm_r) begin
            loop_ref_nxt = i_wr.data;
            arm_nxt = 1'b0;
          end
        end
        ADDR_SCALE_CTRL: begin
          arm_nxt = i_wr.data[ARM_BIT];
          scale_misc_nxt = i_wr.data[5:0];
          scale_b7_nxt = i_wr.data[7];
        end
        default: begin
          // Identification and status ignore writes
          loop_ref_nxt = loop_ref_r;
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Read mux
  //--------------------------------------------------------------------
  always_comb begin
    case (i_rd_addr)
      ADDR_LOOP_REF: rd_nxt = loop_ref_r;
      ADDR_SCALE_CTRL: rd_nxt = {scale_b7_r, arm_r, scale_misc_r};
      ADDR_CHIP_ID: rd_nxt = {VENDOR_CODE, REVISION};
      ADDR_FAULT_STATUS: rd_nxt = status;
      default: rd_nxt = 8'h00;
    endcase
  end

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      loop_ref_r <= LOOP_REF_RESET;
      arm_r <= 1'b0;
      scale_misc_r <= SCALE_CTRL_RESET[5:0];
      scale_b7_r <= 1'b0;
      en_d_r <= 1'b0;
      rd_r <= 8'h00;
      pg_r <= 1'b0;
      direct_r <= 1'b0;
      ref_code_r <= REF_CODE_FIXED;
    end else begin
      loop_ref_r <= loop_ref_nxt;
      arm_r <= arm_nxt;
      scale_misc_r <= scale_misc_nxt;
      scale_b7_r <= scale_b7_nxt;
      en_d_r <= i_enable;
      rd_r <= rd_nxt;
      pg_r <= status[PG_BIT];
      // Registered from the next value so the pins move with the register
      direct_r <= !loop_ref_nxt[LOOP_SEL_BIT];
      // Divider loop always sees the fixed reference code
      ref_code_r <= loop_ref_nxt[LOOP_SEL_BIT] ? REF_CODE_FIXED
                                               : loop_ref_nxt[6:0];
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign o_rd_data = rd_r;
  assign o_direct_loop = direct_r;
  assign o_ref_code = ref_code_r;
  assign o_power_good = pg_r;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  sequence s_arm;
    i_wr.wr && i_wr.addr == ADDR_SCALE_CTRL && i_wr.data[ARM_BIT]
      && i_enable && en_d_r;
  endsequence
  sequence s_loop_wr;
    i_wr.wr && i_wr.addr == ADDR_LOOP_REF && i_enable && en_d_r;
  endsequence

  AST_ARM_CLEARS: assert property (@(posedge i_clk) disable iff (i_srst)
    s_arm ##1 s_loop_wr |=> !arm_r)
    else $error("arming bit did not clear");
  AST_LOAD_ARMED: assert property (@(posedge i_clk) disable iff (i_srst)
    s_loop_wr and arm_r |=> loop_ref_r == $past(i_wr.data))
    else $error("armed loop write not taken");
  AST_NO_UNARMED: assert property (@(posedge i_clk) disable iff (i_srst)
    s_loop_wr and !arm_r |=> $stable(loop_ref_r))
    else $error("unarmed loop write changed output");
  AST_EN_DIVIDER: assert property (@(posedge i_clk) disable iff (i_srst)
    en_rise |=> !o_direct_loop)
    else $error("divider loop not selected on enable");
  AST_FIXED_REF: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_direct_loop |-> o_ref_code == REF_CODE_FIXED)
    else $error("divider reference altered");
  AST_ID_READ: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rd_addr == ADDR_CHIP_ID |=> o_rd_data == {VENDOR_CODE, REVISION})
    else $error("identification read wrong");
  AST_STATUS_RSV: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rd_addr == ADDR_FAULT_STATUS |=> o_rd_data[7:4] == 4'h0)
    else $error("reserved status bits nonzero");
  AST_OC_READ: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rd_addr == ADDR_FAULT_STATUS |=>
      o_rd_data[OC_BIT] == $past(i_mon.overcurrent_flag))
    else $error("over-current bit wrong");
  AST_PG_SRC: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 o_power_good == $past(o_direct_loop ? i_mon.vout_in_window
                                            : i_mon.fb_in_window))
    else $error("power good source wrong");

endmodule

// ==== tb/buck_host_model.sv ====
`timescale 1ns/100ps
// Host on the register path: single byte writes and reads
module buck_host_model
  import buck_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  output reg_wr_s o_wr,
  output logic [7:0] o_rd_addr
);
  // Idle bus before the first request
  initial begin
    o_wr = '0;
    o_rd_addr = 8'h00;
  end
  // One write pulse; released fields flip so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= '{wr: 1'b1, addr: a, data: d};
    @(posedge i_clk);
    o_wr <= '{wr: 1'b0, addr: ~a, data: ~d};
  endtask
  // Read data lands one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd_addr <= a;
    @(posedge i_clk);
    @(negedge i_clk);
    d = i_rd_data;
  endtask
  // Voltage change: arm first, then loop select and code together
  task automatic set_loop(input logic [7:0] v);
    wr(ADDR_SCALE_CTRL, 8'h40);
    wr(ADDR_LOOP_REF, v);
  endtask
endmodule

// ==== tb/buck_loop_select_status_regs_bench.sv ====
`timescale 1ns/100ps
module buck_loop_select_status_regs_bench
  import buck_ctrl_pkg::*;
;
  localparam logic [3:0] VEND = 4'h6; // Arbitrary vendor value
  localparam logic [3:0] REV = 4'h2;
  logic clk;
  logic srst;
  logic enable;
  monitor_s mon;
  reg_wr_s wr_bus;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic direct_loop;
  logic [6:0] ref_code;
  logic power_good;
  logic [7:0] d;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  buck_loop_select_status_regs #(.VENDOR_CODE(VEND), .REVISION(REV)) DUT (
    .i_clk(clk), .i_srst(srst), .i_enable(enable), .i_wr(wr_bus),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data), .i_mon(mon),
    .o_direct_loop(direct_loop), .o_ref_code(ref_code),
    .o_power_good(power_good));
  buck_host_model host (.i_clk(clk), .i_rd_data(rd_data), .o_wr(wr_bus),
    .o_rd_addr(rd_addr));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, far beyond the seventy or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Loop state seen on the core outputs
  task automatic check_loop(input logic dl, input logic [6:0] rc);
    @(negedge clk);
    check("direct_loop", {7'h0, direct_loop}, {7'h0, dl});
    check("ref_code", {1'b0, ref_code}, {1'b0, rc});
  endtask

  task automatic t_reset;
    host.rd(ADDR_LOOP_REF, d);
    check("loop_ref", d, LOOP_REF_RESET);
    host.rd(ADDR_SCALE_CTRL, d);
    check("scale_ctrl", d, SCALE_CTRL_RESET);
    check_loop(1'b0, REF_CODE_FIXED);
    $display("test reset done");
  endtask

  // Read-only places and an unmapped address
  task automatic t_id;
    host.wr(ADDR_CHIP_ID, 8'h00);
    host.wr(ADDR_FAULT_STATUS, 8'hff);
    host.rd(ADDR_CHIP_ID, d);
    check("chip_id", d, {VEND, REV});
    host.rd(8'h07, d);
    check("unmapped", d, 8'h00);
    $display("test id done");
  endtask

  // Walk a single monitor bit, then all of them at once
  task automatic t_status(input logic dl);
    logic [7:0] e;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) mon <= (i == 5) ? 5'h1f : 5'h01 << i;
      host.rd(ADDR_FAULT_STATUS, d);
      e = {4'h0, mon[4:2], dl ? mon[0] : mon[1]};
      check("status", d, e);
      check("power_good", {7'h0, power_good}, {7'h0, e[0]});
    end
    $display("test status done");
  endtask

  // Unarmed write refused, armed write taken once, then repeated
  task automatic t_scale;
    host.wr(ADDR_LOOP_REF, 8'h3c);
    check_loop(1'b0, REF_CODE_FIXED);
    host.set_loop(8'h3c);
    check_loop(1'b1, 7'h3c);
    host.rd(ADDR_SCALE_CTRL, d);
    check("arm", {7'h0, d[ARM_BIT]}, 8'h00);
    host.wr(ADDR_LOOP_REF, 8'h20);
    check_loop(1'b1, 7'h3c);
    host.set_loop(8'h25);
    check_loop(1'b1, 7'h25);
    $display("test scale done");
  endtask

  // Enable drop returns to divider loop; arming while low is refused
  task automatic t_enable;
    @(posedge clk) enable <= 1'b0;
    host.wr(ADDR_SCALE_CTRL, 8'h40);
    @(posedge clk) enable <= 1'b1;
    host.wr(ADDR_LOOP_REF, 8'h30);
    check_loop(1'b0, REF_CODE_FIXED);
    $display("test enable done");
  endtask

  initial begin
    srst = 1'b1;
    enable = 1'b1;
    mon = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_id();
    t_status(1'b0);
    t_scale();
    t_status(1'b1);
    t_enable();
    stop_test();
  end
endmodule
